//--- design/regulator_fault_supervisor.sv
// Fault supervisor: ready output, undervoltage, overvoltage, overcurrent and thermal alarms.
// Notes on behaviour
// - Ready low in shutdown, high after soft-start plus delay.
// - Ready drops on any fault, disable or off-code.
// - Undervoltage below half the VOLTAGE_ID_CODE voltage.
// - Undervoltage clears at six tenths of VOLTAGE_ID_CODE.
// - Overvoltage monitor active right after power-on reset.
// - Fixed 1.275 V trip before valid VOLTAGE_ID_CODE.
// - Trip becomes VOLTAGE_ID_CODE plus 175 mV once valid.
// - Overvoltage start drives all PWM low fast.
// - Below reference plus 75 mV, PWM goes high impedance.
// - Recurring overvoltage alternates low and high impedance.
// - Overvoltage latches off until enable or supply cycles.
// - VOLTAGE_ID_CODE changes never clear the overvoltage latch.
// - Averaged current above 85 uA starts shutdown.
// - Overcurrent puts all PWM high impedance fast.
// - Hold off 4096 switching cycles, then retry soft-start.
// - Trip and retry repeats while overcurrent persists.
// - Channel over 120 uA blanked rest of cycle.
// - Blanked channel resumes next cycle if current low.
// - Peak limit never shuts down the converter.
// - Thermal alarms valid when enabled, open-drain outputs.
// - Cooling request sets below 33%, clears above 39%.
// - Over-temperature sets below 28%, clears above 33%.
// - Ready delay is typically 85 microseconds.
// - Off-code shuts down until supply or enable cycles.
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_supervisor #(
  parameter int N = fault_supervisor_pkg::PHASE_COUNT,
  parameter int READY_DELAY_CYCLES = fault_supervisor_pkg::READY_DELAY_CYCLES,
  parameter int HICCUP_CYCLES = fault_supervisor_pkg::HICCUP_SWITCH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok_in,
  input wire logic power_enable_in,
  input wire logic termination_rail_enable_in,
  input wire logic [fault_supervisor_pkg::VID_WIDTH-1:0] voltage_id_code,
  input wire logic soft_start_done_in,
  input wire logic switch_cycle_tick_in,
  input wire logic [N-1:0] pwm_request_in,
  input wire logic sense_below_half_vid_in,
  input wire logic sense_above_six_tenths_vid_in,
  input wire logic sense_above_fixed_trip_in,
  input wire logic sense_above_vid_trip_in,
  input wire logic differential_sense_below_ref_in,
  input wire logic averaged_channel_current_over_in,
  input wire logic [N-1:0] channel_peak_over_in,
  input wire logic thermal_sense_below_33_in,
  input wire logic thermal_sense_above_39_in,
  input wire logic thermal_sense_below_28_in,
  input wire logic thermal_sense_above_33_in,
  output logic soft_start_run_out,
  output logic [N-1:0] pwm_out,
  output logic [N-1:0] pwm_oe,
  output logic regulator_ready_out,
  output logic regulator_ready_oe,
  output logic overvoltage_guard,
  output logic cooling_request_out,
  output logic cooling_request_oe,
  output logic overtemp_alarm_out,
  output logic overtemp_alarm_oe
);
  localparam int DLY_W = $clog2(READY_DELAY_CYCLES + 1);
  localparam int HIC_W = $clog2(HICCUP_CYCLES + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(READY_DELAY_CYCLES - 1);
  localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(HICCUP_CYCLES - 1);

  function automatic logic is_off_code(input logic [fault_supervisor_pkg::VID_WIDTH-1:0] code);
    is_off_code = (code == fault_supervisor_pkg::VID_OFF_CODE_A) ||
                  (code == fault_supervisor_pkg::VID_OFF_CODE_B);
  endfunction

  fault_supervisor_pkg::sup_state_e state_q;
  fault_supervisor_pkg::sup_state_e state_d;
  logic enabled;
  logic vid_valid_q;
  logic ov_trip;
  logic ov_latched_q;
  logic ov_drive_low_q;
  logic uv_q;
  logic [DLY_W-1:0] delay_cnt_q;
  logic [HIC_W-1:0] hiccup_cnt_q;
  logic regulating;
  logic [N-1:0] pwm_gated;
  logic fan_q;
  logic hot_q;

  assign enabled = supply_ok_in & power_enable_in & termination_rail_enable_in;

  // Trip level: fixed until a valid code has been seen while enabled, then VOLTAGE_ID_CODE plus margin.
  assign ov_trip = vid_valid_q ? sense_above_vid_trip_in : sense_above_fixed_trip_in;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vid_valid_q <= 1'b0;
    end else if (!enabled) begin
      vid_valid_q <= 1'b0;
    end else if (!is_off_code(voltage_id_code)) begin
      vid_valid_q <= 1'b1;
    end
  end

  // The latch arms from reset release regardless of enable and clears only while disabled.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_latched_q <= 1'b0;
    end else if (ov_trip) begin
      ov_latched_q <= 1'b1;
    end else if (!enabled) begin
      ov_latched_q <= 1'b0;
    end
  end

  // Low drive starts on every trip and ends once the differential sense is near reference.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_drive_low_q <= 1'b0;
    end else if (ov_trip) begin
      ov_drive_low_q <= 1'b1;
    end else if (differential_sense_below_ref_in || !ov_latched_q) begin
      ov_drive_low_q <= 1'b0;
    end
  end

  // Undervoltage flag with hysteresis between the two thresholds.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_q <= 1'b0;
    end else if (sense_below_half_vid_in) begin
      uv_q <= 1'b1;
    end else if (sense_above_six_tenths_vid_in) begin
      uv_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      fault_supervisor_pkg::ST_SHUTDOWN: begin
        if (enabled) begin
          state_d = is_off_code(voltage_id_code) ? fault_supervisor_pkg::ST_VID_OFF
                                                 : fault_supervisor_pkg::ST_SOFT_START;
        end
      end
      fault_supervisor_pkg::ST_SOFT_START: begin
        if (soft_start_done_in) begin
          state_d = fault_supervisor_pkg::ST_READY_WAIT;
        end
      end
      fault_supervisor_pkg::ST_READY_WAIT: begin
        if (delay_cnt_q == DLY_LAST) begin
          state_d = fault_supervisor_pkg::ST_RUN;
        end
      end
      fault_supervisor_pkg::ST_RUN: begin
        state_d = fault_supervisor_pkg::ST_RUN;
      end
      fault_supervisor_pkg::ST_HICCUP: begin
        if (switch_cycle_tick_in && hiccup_cnt_q == HIC_LAST) begin
          state_d = fault_supervisor_pkg::ST_SOFT_START;
        end
      end
      fault_supervisor_pkg::ST_VID_OFF: begin
        state_d = fault_supervisor_pkg::ST_VID_OFF;
      end
      fault_supervisor_pkg::ST_OV_LATCHED: begin
        state_d = fault_supervisor_pkg::ST_OV_LATCHED;
      end
      default: begin
        state_d = fault_supervisor_pkg::ST_SHUTDOWN;
      end
    endcase
    if (regulating && averaged_channel_current_over_in) begin
      state_d = fault_supervisor_pkg::ST_HICCUP;
    end
    if (regulating && is_off_code(voltage_id_code)) begin
      state_d = fault_supervisor_pkg::ST_VID_OFF;
    end
    if (enabled && (ov_trip || ov_latched_q)) begin
      state_d = fault_supervisor_pkg::ST_OV_LATCHED;
    end
    if (!enabled) begin
      state_d = fault_supervisor_pkg::ST_SHUTDOWN;
    end
  end

  assign regulating = (state_q == fault_supervisor_pkg::ST_SOFT_START) ||
                      (state_q == fault_supervisor_pkg::ST_READY_WAIT) ||
                      (state_q == fault_supervisor_pkg::ST_RUN);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= fault_supervisor_pkg::ST_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // Ready delay counter runs only while waiting after the soft-start ramp.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt_q <= '0;
    end else if (state_q == fault_supervisor_pkg::ST_READY_WAIT) begin
      delay_cnt_q <= delay_cnt_q + DLY_W'(1);
    end else begin
      delay_cnt_q <= '0;
    end
  end

  // Hiccup counter advances once per switching period and restarts at each trip.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiccup_cnt_q <= '0;
    end else if (state_q != fault_supervisor_pkg::ST_HICCUP) begin
      hiccup_cnt_q <= '0;
    end else if (switch_cycle_tick_in) begin
      hiccup_cnt_q <= hiccup_cnt_q + HIC_W'(1);
    end
  end

  peak_limit_if #(.N(N)) plim ();
  assign plim.switch_tick = switch_cycle_tick_in;
  assign plim.pwm_request = pwm_request_in;
  assign plim.peak_over = channel_peak_over_in;
  assign pwm_gated = plim.pwm_allowed;

  peak_current_limiter #(.N(N)) u_limiter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lim(plim.limiter)
  );

  // PWM drive: overvoltage low drive wins, faults release, regulating passes limited PWM.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= '0;
      pwm_oe <= '0;
    end else if (ov_trip || ov_drive_low_q) begin
      pwm_out <= '0;
      pwm_oe <= '1;
    end else if (ov_latched_q || !regulating || averaged_channel_current_over_in) begin
      pwm_out <= '0;
      pwm_oe <= '0;
    end else begin
      pwm_out <= pwm_gated;
      pwm_oe <= '1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_start_run_out <= 1'b0;
    end else begin
      soft_start_run_out <= (state_d == fault_supervisor_pkg::ST_SOFT_START);
    end
  end

  // Ready is an open-drain pin: pulled low unless running clean.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regulator_ready_out <= 1'b0;
      regulator_ready_oe <= 1'b1;
    end else begin
      regulator_ready_out <= 1'b0;
      regulator_ready_oe <= !((state_d == fault_supervisor_pkg::ST_RUN) && !uv_q &&
                              !sense_below_half_vid_in);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overvoltage_guard <= 1'b0;
    end else begin
      overvoltage_guard <= ov_trip || ov_latched_q;
    end
  end

  // Thermal comparators with hysteresis, cleared while the controller is disabled.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_q <= 1'b0;
      hot_q <= 1'b0;
    end else if (!enabled) begin
      fan_q <= 1'b0;
      hot_q <= 1'b0;
    end else begin
      if (thermal_sense_below_33_in) begin
        fan_q <= 1'b1;
      end else if (thermal_sense_above_39_in) begin
        fan_q <= 1'b0;
      end
      if (thermal_sense_below_28_in) begin
        hot_q <= 1'b1;
      end else if (thermal_sense_above_33_in) begin
        hot_q <= 1'b0;
      end
    end
  end

  // Open-drain alarms: asserted means released high, otherwise pulled low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cooling_request_out <= 1'b0;
      cooling_request_oe <= 1'b1;
      overtemp_alarm_out <= 1'b0;
      overtemp_alarm_oe <= 1'b1;
    end else begin
      cooling_request_out <= 1'b0;
      cooling_request_oe <= !fan_q;
      overtemp_alarm_out <= 1'b0;
      overtemp_alarm_oe <= !hot_q;
    end
  end
endmodule
`default_nettype wire

//--- design/fault_supervisor_pkg.sv
// Package with the timing, code and state definitions of the regulator fault supervisor.
package fault_supervisor_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int READY_DELAY_NS = 85000;
  localparam int READY_DELAY_CYCLES = (READY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWM_RESPONSE_NS = 20;
  localparam int PWM_RESPONSE_CYCLES = (PWM_RESPONSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int HICCUP_SWITCH_CYCLES = 4096;
  localparam int PHASE_COUNT = 6;
  localparam int VID_WIDTH = 8;
  localparam logic [7:0] VID_OFF_CODE_A = 8'hFE;
  localparam logic [7:0] VID_OFF_CODE_B = 8'hFF;

  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b000,
    ST_SOFT_START = 3'b001,
    ST_READY_WAIT = 3'b010,
    ST_RUN = 3'b011,
    ST_HICCUP = 3'b100,
    ST_VID_OFF = 3'b101,
    ST_OV_LATCHED = 3'b110
  } sup_state_e;
endpackage

//--- design/peak_limit_if.sv
// Interface between the supervisor and its per-channel peak current limiter.
`timescale 1ns/1ps
`default_nettype none
interface peak_limit_if #(
  parameter int N = 6
);
  logic switch_tick;
  logic [N-1:0] pwm_request;
  logic [N-1:0] peak_over;
  logic [N-1:0] pwm_allowed;

  modport limiter (input switch_tick, input pwm_request, input peak_over, output pwm_allowed);
  modport supervisor (output switch_tick, output pwm_request, output peak_over, input pwm_allowed);
endinterface
`default_nettype wire

//--- design/peak_current_limiter.sv
// Per-channel peak current limiter that blanks a phase for the rest of its switching cycle.
`timescale 1ns/1ps
`default_nettype none
module peak_current_limiter #(
  parameter int N = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  peak_limit_if.limiter lim
);
  logic [N-1:0] blanked_q;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      // A trip blanks the channel; the next cycle start releases it only if current is low.
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          blanked_q[g] <= 1'b0;
        end else if (lim.peak_over[g]) begin
          blanked_q[g] <= 1'b1;
        end else if (lim.switch_tick) begin
          blanked_q[g] <= 1'b0;
        end
      end
      assign lim.pwm_allowed[g] = lim.pwm_request[g] & ~blanked_q[g] & ~lim.peak_over[g];
    end
  endgenerate
endmodule
`default_nettype wire

//--- verif/supervisor_chk.sv
// Port assertions for the regulator fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module supervisor_chk #(
  parameter int N = 6,
  parameter int READY_DELAY_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok_in,
  input wire logic power_enable_in,
  input wire logic termination_rail_enable_in,
  input wire logic sense_below_half_vid_in,
  input wire logic sense_above_fixed_trip_in,
  input wire logic sense_above_vid_trip_in,
  input wire logic differential_sense_below_ref_in,
  input wire logic averaged_channel_current_over_in,
  input wire logic [N-1:0] channel_peak_over_in,
  input wire logic thermal_sense_below_33_in,
  input wire logic soft_start_run_out,
  input wire logic [N-1:0] pwm_out,
  input wire logic [N-1:0] pwm_oe,
  input wire logic regulator_ready_oe,
  input wire logic overvoltage_guard,
  input wire logic cooling_request_oe
);
  logic en;
  int wait_q;
  assign en = supply_ok_in && power_enable_in && termination_rail_enable_in;
  // Counts cycles since soft-start was last active.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 0;
    end else if (soft_start_run_out) begin
      wait_q <= 0;
    end else if (wait_q < 1000000) begin
      wait_q <= wait_q + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_on;
    en && $past(en);
  endsequence
  sequence s_trip_gone;
    !sense_above_vid_trip_in && !sense_above_fixed_trip_in;
  endsequence
  property p_fixed;
    !power_enable_in && supply_ok_in && sense_above_fixed_trip_in |=> overvoltage_guard;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed trip missed");
  property p_ov_low;
    s_on ##0 sense_above_vid_trip_in |=> pwm_oe == '1 && pwm_out == '0 && regulator_ready_oe;
  endproperty
  a_ov_low: assert property (p_ov_low)
    else $error("pwm not low on overvoltage");
  property p_ov_hiz;
    overvoltage_guard && differential_sense_below_ref_in ##0 s_trip_gone
      ##1 s_trip_gone |=> pwm_oe == '0;
  endproperty
  a_ov_hiz: assert property (p_ov_hiz)
    else $error("pwm not released");
  property p_latch;
    overvoltage_guard && en |=> overvoltage_guard && pwm_out == '0;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch lost");
  property p_uv;
    sense_below_half_vid_in || !en |=> regulator_ready_oe;
  endproperty
  a_uv: assert property (p_uv)
    else $error("ready not low");
  property p_delay;
    $fell(regulator_ready_oe) |-> wait_q >= READY_DELAY_CYCLES - 2;
  endproperty
  a_delay: assert property (p_delay)
    else $error("ready early");
  property p_ocp;
    soft_start_run_out && averaged_channel_current_over_in && !overvoltage_guard
      && !sense_above_vid_trip_in |=> pwm_oe == '0 && regulator_ready_oe;
  endproperty
  a_ocp: assert property (p_ocp)
    else $error("overcurrent missed");
  property p_peak;
    channel_peak_over_in != '0 |=> (pwm_out & $past(channel_peak_over_in)) == '0;
  endproperty
  a_peak: assert property (p_peak)
    else $error("phase not blanked");
  property p_fan;
    s_on ##0 thermal_sense_below_33_in ##1 en |=> !cooling_request_oe;
  endproperty
  a_fan: assert property (p_fan)
    else $error("cooling request missed");
endmodule
`default_nettype wire

//--- verif/driver_monitor_model.sv
// Phase drivers, monitor pull-up and switching clock around the supervisor.
`timescale 1ns/1ps
`default_nettype none
module driver_monitor_model #(
  parameter int N = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [N-1:0] pwm_out,
  input wire logic [N-1:0] pwm_oe,
  input wire logic regulator_ready_out,
  input wire logic regulator_ready_oe,
  output logic switch_tick,
  output logic [N-1:0] lower_on,
  output logic ready_pin
);
  logic [2:0] phase_q;
  // A switching cycle starts every eight clocks.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_q + 3'h1;
    end
  end
  assign switch_tick = (phase_q == 3'h7);
  // A driver turns its lower switch on only while its input is driven low.
  assign lower_on = pwm_oe & ~pwm_out;
  // The pull-up reads high whenever the open-drain pin is released.
  assign ready_pin = regulator_ready_oe ? regulator_ready_out : 1'b1;
endmodule
`default_nettype wire

//--- verif/regulator_fault_supervisor_tb.sv
// Self-checking bench for the regulator fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_supervisor_tb;
  localparam int N = 6;
  localparam int READY_DELAY_CYCLES = 20;
  localparam int HC = 4;
  logic sys_clk = 0, rst_n = 0, supply_ok_in = 1, power_enable_in = 0;
  logic termination_rail_enable_in = 0, soft_start_done_in = 0, switch_cycle_tick_in;
  logic [7:0] voltage_id_code = 8'h40;
  logic sense_below_half_vid_in = 0, sense_above_six_tenths_vid_in = 1;
  logic sense_above_fixed_trip_in = 0, sense_above_vid_trip_in = 0;
  logic differential_sense_below_ref_in = 0, averaged_channel_current_over_in = 0;
  logic thermal_sense_below_33_in = 0, thermal_sense_above_39_in = 1;
  logic thermal_sense_below_28_in = 0, thermal_sense_above_33_in = 1;
  logic [N-1:0] pwm_request_in = 6'h2D, channel_peak_over_in = 6'h00;
  logic soft_start_run_out, regulator_ready_out, regulator_ready_oe, overvoltage_guard;
  logic cooling_request_out, cooling_request_oe, overtemp_alarm_out, overtemp_alarm_oe;
  logic ready_pin;
  logic [N-1:0] pwm_out, pwm_oe, lower_on;
  int mismatches = 0, check_count = 0;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
  always #2.5 sys_clk = ~sys_clk;
  regulator_fault_supervisor #(.N(N), .READY_DELAY_CYCLES(READY_DELAY_CYCLES),
    .HICCUP_CYCLES(HC)) dut (.*);
  driver_monitor_model #(.N(N)) partner (.sys_clk, .rst_n, .pwm_out, .pwm_oe,
    .regulator_ready_out, .regulator_ready_oe, .switch_tick(switch_cycle_tick_in),
    .lower_on, .ready_pin);
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic enable(input logic v);
    power_enable_in = v;
    termination_rail_enable_in = v;
    cyc(2);
  endtask
  task automatic wait_ss(input logic v);
    int i;
    i = 0;
    while (soft_start_run_out !== v && i < 200) begin
      cyc(1);
      i++;
    end
    `CHK(soft_start_run_out, v)
  endtask
  task automatic set_tm(input int lv);
    thermal_sense_below_33_in = lv < 33;
    thermal_sense_above_39_in = lv > 39;
    thermal_sense_below_28_in = lv < 28;
    thermal_sense_above_33_in = lv > 33;
    cyc(2);
  endtask
  task automatic t_fixed;
    sense_above_fixed_trip_in = 1;
    cyc(1);
    `CHK(overvoltage_guard, 1'b1)
    sense_above_fixed_trip_in = 0;
    set_tm(25);
    `CHK({cooling_request_oe, overtemp_alarm_oe}, 2'h3)
    set_tm(50);
    enable(1);
    wait_ss(1);
    sense_above_fixed_trip_in = 1;
    cyc(2);
    `CHK(overvoltage_guard, 1'b0)
    sense_above_fixed_trip_in = 0;
    enable(0);
  endtask
  task automatic t_offcode;
    for (int i = 0; i < 2; i++) begin
      voltage_id_code = i ? 8'hFF : 8'hFE;
      enable(1);
      cyc(10);
      `CHK({soft_start_run_out, ready_pin, pwm_oe}, 8'h00)
      voltage_id_code = 8'h40;
      cyc(10);
      `CHK(soft_start_run_out, 1'b0)
      if (i == 1) begin
        supply_ok_in = 0;
        cyc(2);
        supply_ok_in = 1;
        wait_ss(1);
      end
      enable(0);
    end
  endtask
  task automatic t_startup;
    int n;
    enable(1);
    wait_ss(1);
    `CHK(ready_pin, 1'b0)
    soft_start_done_in = 1;
    n = 0;
    while (ready_pin !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    `CHK(n >= READY_DELAY_CYCLES + 1 && n <= READY_DELAY_CYCLES + 2, 1'b1)
    `CHK(pwm_out, pwm_request_in)
  endtask
  task automatic t_uv;
    sense_below_half_vid_in = 1;
    sense_above_six_tenths_vid_in = 0;
    cyc(2);
    `CHK(ready_pin, 1'b0)
    sense_below_half_vid_in = 0;
    cyc(2);
    `CHK(ready_pin, 1'b0)
    sense_above_six_tenths_vid_in = 1;
    cyc(2);
    `CHK(ready_pin, 1'b1)
  endtask
  task automatic t_peak;
    channel_peak_over_in = 6'h04;
    cyc(10);
    `CHK(pwm_out, 6'h29)
    `CHK(ready_pin, 1'b1)
    channel_peak_over_in = 6'h00;
    cyc(10);
    `CHK(pwm_out, 6'h2D)
  endtask
  task automatic t_thermal;
    int lv[9] = '{50, 35, 30, 35, 40, 25, 30, 35, 50};
    logic [8:0] fan = 9'h0EC;
    logic [8:0] hot = 9'h060;
    for (int i = 0; i < 9; i++) begin
      set_tm(lv[i]);
      `CHK(cooling_request_oe, ~fan[i])
      `CHK(overtemp_alarm_oe, ~hot[i])
    end
    `CHK({cooling_request_out, overtemp_alarm_out}, 2'h0)
  endtask
  task automatic t_ocp;
    int ticks;
    averaged_channel_current_over_in = 1;
    cyc(1);
    `CHK({ready_pin, pwm_oe}, 7'h00)
    ticks = 0;
    for (int i = 0; i < 200 && soft_start_run_out !== 1'b1; i++) begin
      if (switch_cycle_tick_in === 1'b1) ticks++;
      cyc(1);
    end
    `CHK(ticks >= HC && ticks <= HC + 1, 1'b1)
    cyc(2);
    `CHK({soft_start_run_out, pwm_oe}, 7'h00)
    averaged_channel_current_over_in = 0;
    wait_ss(1);
    cyc(READY_DELAY_CYCLES + 4);
    `CHK(ready_pin, 1'b1)
  endtask
  task automatic t_ov;
    sense_above_vid_trip_in = 1;
    averaged_channel_current_over_in = 1;
    cyc(1);
    `CHK({overvoltage_guard, ready_pin, lower_on}, 8'hBF)
    sense_above_vid_trip_in = 0;
    averaged_channel_current_over_in = 0;
    differential_sense_below_ref_in = 1;
    cyc(2);
    `CHK(pwm_oe, 6'h00)
    sense_above_vid_trip_in = 1;
    cyc(1);
    `CHK(lower_on, 6'h3F)
    sense_above_vid_trip_in = 0;
    voltage_id_code = 8'h20;
    cyc(4);
    `CHK({overvoltage_guard, pwm_oe}, 7'h40)
    enable(0);
    `CHK(overvoltage_guard, 1'b0)
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    cyc(8);
    rst_n = 1;
    t_fixed();
    t_offcode();
    t_startup();
    t_uv();
    t_peak();
    t_thermal();
    t_ocp();
    t_ov();
    final_report();
  end
endmodule
bind regulator_fault_supervisor supervisor_chk #(.N(N),
  .READY_DELAY_CYCLES(READY_DELAY_CYCLES)) chk (.*);
`default_nettype wire
